/* File: src/cld_defs.svh */
// cold load detector constants: register offsets, field positions, reset values
// assumes inclusion by the package and the design modules of this block only
`ifndef CLD_DEFS_SVH
`define CLD_DEFS_SVH

`define CLD_ADDR_W        6
`define CLD_CUR_W         16
`define CLD_TMR_W         32

// register byte offsets
`define CLD_OFS_CTRL      6'h00
`define CLD_OFS_LOADOFF   6'h04
`define CLD_OFS_SETTLE    6'h08
`define CLD_OFS_MAXBLK    6'h0C
`define CLD_OFS_INRUSH    6'h10
`define CLD_OFS_STATUS    6'h14
`define CLD_OFS_IRQ_STAT  6'h18
`define CLD_OFS_IRQ_MASK  6'h1C

// control fields
`define CLD_CTRL_EN       0
`define CLD_CTRL_MODE_LO  1
`define CLD_CTRL_MODE_HI  2
`define CLD_CTRL_EXTBLK   3
`define CLD_CTRL_SWBLK    4
`define CLD_CTRL_ARBLK    5

// interrupt bits
`define CLD_IRQ_ON        0
`define CLD_IRQ_OFF       1
`define CLD_IRQ_INRUSH    2
`define CLD_IRQ_MAXBLK    3
`define CLD_IRQ_W         4

// reset values
`define CLD_CTRL_RST      32'h0000_0021
`define CLD_LOADOFF_RST   32'h0000_2710
`define CLD_SETTLE_RST    32'h0000_03E8
`define CLD_MAXBLK_RST    32'h0000_C350
`define CLD_INRUSH_RST    32'h0000_1000
`define CLD_MASK_RST      32'h0000_0000

// bus responses
`define CLD_RESP_OKAY     2'h0
`define CLD_RESP_SLVERR   2'h2

`endif

/* File: src/cld_pkg.sv */
// cold load detector types shared by the bus slave and the core
// assumes cld_defs.svh sits beside it on the include path
`include "cld_defs.svh"

package cld_pkg;
    // cold detection modes, in the order of the control field
    typedef enum logic [1:0] {
        CLD_MODE_BRK,
        CLD_MODE_UC,
        CLD_MODE_AND,
        CLD_MODE_OR
    } cld_mode_e;

    // supervision sequence
    typedef enum logic [1:0] {
        CLD_WARM,
        CLD_LOADOFF,
        CLD_COLD,
        CLD_RECOVER
    } cld_state_e;

    // one register write taken from the bus
    typedef struct packed {
        logic [`CLD_ADDR_W-1:0] addr;
        logic [31:0]            data;
        logic [3:0]             strb;
    } cld_wreq_s;
endpackage

/* File: src/cld_timer.sv */
// delay timer: counts clock cycles while enabled, clears whenever disabled
// assumes the enable falls at least one cycle between two timed intervals
`timescale 1ns/1ns
`include "cld_defs.svh"

module cld_timer #(
    parameter int W = `CLD_TMR_W
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         en,      // run request, low clears
    input  wire logic [W-1:0] preset,  // cycles to expiry
    output logic              done     // level, high once preset reached
);
    logic [W-1:0] cnt_q;               // elapsed cycles

    assign done = en && (cnt_q >= preset);

    // counter stops at the preset so it never wraps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (!en) begin
            cnt_q <= '0;
        end else if (!done) begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule

/* File: src/cld_axil.sv */
// axi4-lite slave front end: turns bus traffic into single-cycle strobes
// assumes the core decodes addresses combinationally and answers in the same cycle
`timescale 1ns/1ns
`include "cld_defs.svh"

module cld_axil (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [`CLD_ADDR_W-1:0] awaddr,
    input  wire logic                   wvalid,
    output logic                        wready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    output logic                        bvalid,
    input  wire logic                   bready,
    output logic [1:0]                  bresp,
    input  wire logic                   arvalid,
    output logic                        arready,
    input  wire logic [`CLD_ADDR_W-1:0] araddr,
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        wr_en,     // one-cycle write strobe
    output cld_pkg::cld_wreq_s          wr_req,    // write address, data, lanes
    input  wire logic                   wr_ok,     // write address is mapped
    output logic                        rd_en,     // one-cycle read strobe
    input  wire logic [31:0]            rd_data,   // core read mux
    input  wire logic                   rd_ok      // read address is mapped
);
    // both write channels are waited for, then taken in one edge
    assign wr_en  = awvalid && wvalid && !awready && !bvalid;
    assign wr_req = '{addr: awaddr, data: wdata, strb: wstrb};
    assign rd_en  = arvalid && !arready && !rvalid;

    // write channels and response
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `CLD_RESP_OKAY;
        end else begin
            awready <= wr_en;
            wready  <= wr_en;
            if (wr_en) begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? `CLD_RESP_OKAY : `CLD_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channels; data captured at the accepting edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `CLD_RESP_OKAY;
        end else begin
            arready <= rd_en;
            if (rd_en) begin
                rvalid <= 1'b1;
                rdata  <= rd_ok ? rd_data : 32'h0000_0000;
                rresp  <= rd_ok ? `CLD_RESP_OKAY : `CLD_RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

/* File: src/cld_top.sv */
// cold load detector core with its register file and interrupt logic
// assumes breaker, undercurrent and current-magnitude inputs are synchronous to CLK
//
// Notes on behaviour
// - four cold modes: breaker, undercurrent, and, or
// - warm-to-cold transition starts load-off delay
// - load-off expiry raises cold-load active output
// - cold end starts inrush tracking
// - inrush seen when current exceeds threshold
// - inrush over at ninety percent of threshold
// - settle timer expiry releases active output
// - max-block expiry releases output despite inrush
// - active held no longer than max-block time after cold ends
// - settle below ninety percent stops max-block early
// - selectable external or internal block suppresses all
// - running auto-reclose blocks function when selected
// - only an indication, never a trip
`timescale 1ns/1ns
`include "cld_defs.svh"

module cld_top (
    input  wire logic                   CLK,
    input  wire logic                   NRST,
    input  wire logic                   BREAKER_POSITION_STATE, // high while breaker open
    input  wire logic                   UNDERCURRENT,           // high while below undercurrent level
    input  wire logic [`CLD_CUR_W-1:0]  LOAD_CURRENT,           // load current magnitude
    input  wire logic                   EXT_BLOCK,              // external blocking input
    input  wire logic                   AUTO_RECLOSE_RUNNING,   // reclose sequence in progress
    output logic                        COLD_LOAD_ACTIVE,       // block/desensitise indication
    output logic                        IRQ,
    input  wire logic                   S_AXI_AWVALID,
    output logic                        S_AXI_AWREADY,
    input  wire logic [`CLD_ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                   S_AXI_WVALID,
    output logic                        S_AXI_WREADY,
    input  wire logic [31:0]            S_AXI_WDATA,
    input  wire logic [3:0]             S_AXI_WSTRB,
    output logic                        S_AXI_BVALID,
    input  wire logic                   S_AXI_BREADY,
    output logic [1:0]                  S_AXI_BRESP,
    input  wire logic                   S_AXI_ARVALID,
    output logic                        S_AXI_ARREADY,
    input  wire logic [`CLD_ADDR_W-1:0] S_AXI_ARADDR,
    output logic                        S_AXI_RVALID,
    input  wire logic                   S_AXI_RREADY,
    output logic [31:0]                 S_AXI_RDATA,
    output logic [1:0]                  S_AXI_RRESP
);
    // byte-lane merge of a write into a register
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // current at or below 0.9 of the threshold, as 10*cur <= 9*thr
    function automatic logic below_90(input logic [`CLD_CUR_W-1:0] cur, input logic [`CLD_CUR_W-1:0] thr);
        logic [`CLD_CUR_W+3:0] c10;
        logic [`CLD_CUR_W+3:0] t9;
        c10 = ({4'h0, cur} << 3) + ({4'h0, cur} << 1);
        t9  = ({4'h0, thr} << 3) + {4'h0, thr};
        return c10 <= t9;
    endfunction

    logic                 wr_en;       // bus write strobe
    cld_pkg::cld_wreq_s   wr_req;      // bus write request
    logic                 rd_en;       // bus read strobe
    logic [31:0]          rd_data;     // read mux
    logic                 rd_ok;       // read address mapped
    logic                 wr_ok;       // write address mapped
    logic [31:0]          ctrl_q;      // enable, mode, block selections
    logic [31:0]          loadoff_q;   // load-off delay, cycles
    logic [31:0]          settle_q;    // settle delay, cycles
    logic [31:0]          maxblk_q;    // max-block delay, cycles
    logic [31:0]          inrush_q;    // inrush threshold in low bits
    logic [`CLD_IRQ_W-1:0] irq_stat_q; // sticky events
    logic [`CLD_IRQ_W-1:0] irq_mask_q; // event enables
    logic [`CLD_IRQ_W-1:0] irq_evt;    // events this cycle
    cld_pkg::cld_state_e  state_q;     // sequence state
    cld_pkg::cld_state_e  state_d;
    logic                 inrush_q_f;  // inrush under way: set above threshold, cleared at 90 percent
    logic                 act_d;       // next active output
    logic                 lo_done;     // load-off expired
    logic                 st_done;     // settle expired
    logic                 mb_done;     // max-block expired
    logic                 blocked;     // disabled or any selected block active

    // ---- bus front end ----
    cld_axil u_bus (
        .clk     (CLK),
        .nrst    (NRST),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .awaddr  (S_AXI_AWADDR),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .bresp   (S_AXI_BRESP),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .araddr  (S_AXI_ARADDR),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .wr_en   (wr_en),
        .wr_req  (wr_req),
        .wr_ok   (wr_ok),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // ---- decode ----
    wire [`CLD_ADDR_W-1:0] ra       = S_AXI_ARADDR;
    wire                   w_ctrl   = wr_en && wr_req.addr == `CLD_OFS_CTRL;
    wire                   w_lo     = wr_en && wr_req.addr == `CLD_OFS_LOADOFF;
    wire                   w_st     = wr_en && wr_req.addr == `CLD_OFS_SETTLE;
    wire                   w_mb     = wr_en && wr_req.addr == `CLD_OFS_MAXBLK;
    wire                   w_ir     = wr_en && wr_req.addr == `CLD_OFS_INRUSH;
    wire                   w_mask   = wr_en && wr_req.addr == `CLD_OFS_IRQ_MASK;
    wire                   rd_clr   = rd_en && ra == `CLD_OFS_IRQ_STAT;   // read clears status

    // status and irq status are read-only; writes to them are accepted and ignored
    assign wr_ok = (wr_req.addr[1:0] == 2'h0) && (wr_req.addr <= `CLD_OFS_IRQ_MASK);
    assign rd_ok = (ra[1:0] == 2'h0) && (ra <= `CLD_OFS_IRQ_MASK);

    // read mux
    always_comb begin
        case (ra)
            `CLD_OFS_CTRL:     rd_data = ctrl_q;
            `CLD_OFS_LOADOFF:  rd_data = loadoff_q;
            `CLD_OFS_SETTLE:   rd_data = settle_q;
            `CLD_OFS_MAXBLK:   rd_data = maxblk_q;
            `CLD_OFS_INRUSH:   rd_data = {16'h0000, inrush_q[`CLD_CUR_W-1:0]};
            `CLD_OFS_STATUS:   rd_data = {27'h0000000, blocked, inrush_q_f, state_q, COLD_LOAD_ACTIVE};
            `CLD_OFS_IRQ_STAT: rd_data = {28'h0000000, irq_stat_q};
            `CLD_OFS_IRQ_MASK: rd_data = {28'h0000000, irq_mask_q};
            default:           rd_data = 32'h0000_0000;
        endcase
    end

    // configuration registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q     <= `CLD_CTRL_RST;
            loadoff_q  <= `CLD_LOADOFF_RST;
            settle_q   <= `CLD_SETTLE_RST;
            maxblk_q   <= `CLD_MAXBLK_RST;
            inrush_q   <= `CLD_INRUSH_RST;
            irq_mask_q <= `CLD_IRQ_W'(`CLD_MASK_RST);
        end else begin
            if (w_ctrl) ctrl_q <= lane_merge(ctrl_q, wr_req.data, wr_req.strb) & 32'h0000_003F;
            if (w_lo)   loadoff_q <= lane_merge(loadoff_q, wr_req.data, wr_req.strb);
            if (w_st)   settle_q <= lane_merge(settle_q, wr_req.data, wr_req.strb);
            if (w_mb)   maxblk_q <= lane_merge(maxblk_q, wr_req.data, wr_req.strb);
            if (w_ir)   inrush_q <= lane_merge(inrush_q, wr_req.data, wr_req.strb) & 32'h0000_FFFF;
            if (w_mask) irq_mask_q <= wr_req.data[`CLD_IRQ_W-1:0];
        end
    end

    // ---- cold detection and blocking ----
    wire [1:0] mode_f = ctrl_q[`CLD_CTRL_MODE_HI:`CLD_CTRL_MODE_LO];
    logic      cold;                   // selected cold condition
    always_comb begin
        case (cld_pkg::cld_mode_e'(mode_f))
            cld_pkg::CLD_MODE_BRK: cold = BREAKER_POSITION_STATE;
            cld_pkg::CLD_MODE_UC:  cold = UNDERCURRENT;
            cld_pkg::CLD_MODE_AND: cold = BREAKER_POSITION_STATE && UNDERCURRENT;
            cld_pkg::CLD_MODE_OR:  cold = BREAKER_POSITION_STATE || UNDERCURRENT;
            default:               cold = 1'b0;
        endcase
    end

    // disabled counts as blocked, so one term parks everything
    assign blocked = !ctrl_q[`CLD_CTRL_EN]
                   || ctrl_q[`CLD_CTRL_SWBLK]
                   || (ctrl_q[`CLD_CTRL_EXTBLK] && EXT_BLOCK)
                   || (ctrl_q[`CLD_CTRL_ARBLK] && AUTO_RECLOSE_RUNNING);

    wire thr_above = LOAD_CURRENT > inrush_q[`CLD_CUR_W-1:0];
    wire thr_low   = below_90(LOAD_CURRENT, inrush_q[`CLD_CUR_W-1:0]);
    wire in_rec    = state_q == cld_pkg::CLD_RECOVER;

    // ---- timers: enable low clears, so each new start counts from zero ----
    cld_timer u_loadoff (
        .clk    (CLK),
        .nrst   (NRST),
        .en     (state_q == cld_pkg::CLD_LOADOFF && !blocked),
        .preset (loadoff_q),
        .done   (lo_done)
    );
    // settle runs only while current sits at or below 90 percent
    cld_timer u_settle (
        .clk    (CLK),
        .nrst   (NRST),
        .en     (in_rec && thr_low && !blocked),
        .preset (settle_q),
        .done   (st_done)
    );
    cld_timer u_maxblk (
        .clk    (CLK),
        .nrst   (NRST),
        .en     (in_rec && !blocked),
        .preset (maxblk_q),
        .done   (mb_done)
    );

    // ---- sequence ----
    always_comb begin
        state_d = state_q;
        case (state_q)
            cld_pkg::CLD_WARM:    if (cold) state_d = cld_pkg::CLD_LOADOFF;
            cld_pkg::CLD_LOADOFF: begin
                if (!cold) begin
                    state_d = cld_pkg::CLD_WARM;
                end else if (lo_done) begin
                    state_d = cld_pkg::CLD_COLD;
                end
            end
            cld_pkg::CLD_COLD:    if (!cold) state_d = cld_pkg::CLD_RECOVER;
            // settle completion also ends max-block early
            cld_pkg::CLD_RECOVER: begin
                if (cold) begin
                    state_d = cld_pkg::CLD_COLD;
                end else if (st_done || mb_done) begin
                    state_d = cld_pkg::CLD_WARM;
                end
            end
            default:              state_d = cld_pkg::CLD_WARM;
        endcase
        if (blocked) state_d = cld_pkg::CLD_WARM;
    end

    assign act_d = state_d == cld_pkg::CLD_COLD || state_d == cld_pkg::CLD_RECOVER;

    // state, active output and inrush flag; output is indication only
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_q          <= cld_pkg::CLD_WARM;
            COLD_LOAD_ACTIVE <= 1'b0;
            inrush_q_f       <= 1'b0;
        end else begin
            state_q          <= state_d;
            COLD_LOAD_ACTIVE <= act_d;
            if (!in_rec || blocked) begin
                inrush_q_f <= 1'b0;
            end else if (thr_above) begin
                inrush_q_f <= 1'b1;
            end else if (thr_low) begin
                inrush_q_f <= 1'b0;
            end
        end
    end

    // ---- interrupts: set wins over read-clear ----
    assign irq_evt = {in_rec && mb_done && !cold,
                      in_rec && thr_above && !inrush_q_f,
                      COLD_LOAD_ACTIVE && !act_d,
                      !COLD_LOAD_ACTIVE && act_d};
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_stat_q <= '0;
            IRQ        <= 1'b0;
        end else begin
            irq_stat_q <= (rd_clr ? '0 : irq_stat_q) | irq_evt;
            IRQ        <= |(((rd_clr ? '0 : irq_stat_q) | irq_evt) & irq_mask_q);
        end
    end

    // ---- checks ----
    sequence rec_entry;
        state_q == cld_pkg::CLD_COLD && !cold && !blocked;
    endsequence

    mode_and_a: assert property (@(posedge CLK) disable iff (!NRST)
        (mode_f == 2'h2 && state_q == cld_pkg::CLD_WARM && !blocked && BREAKER_POSITION_STATE && !UNDERCURRENT)
        |=> state_q == cld_pkg::CLD_WARM)
        else $error("and mode left warm with only one condition");
    loadoff_start_a: assert property (@(posedge CLK) disable iff (!NRST)
        (state_q == cld_pkg::CLD_WARM && cold && !blocked) |=> state_q == cld_pkg::CLD_LOADOFF)
        else $error("cold transition did not start load-off");
    active_on_a: assert property (@(posedge CLK) disable iff (!NRST)
        (state_q == cld_pkg::CLD_LOADOFF && lo_done && cold && !blocked) |=> COLD_LOAD_ACTIVE)
        else $error("active not raised on load-off expiry");
    recover_start_a: assert property (@(posedge CLK) disable iff (!NRST)
        rec_entry |=> in_rec && COLD_LOAD_ACTIVE)
        else $error("cold end did not start recovery");
    inrush_seen_a: assert property (@(posedge CLK) disable iff (!NRST)
        (in_rec && thr_above && !blocked && !cold) |=> inrush_q_f)
        else $error("inrush above threshold not registered");
    inrush_over_a: assert property (@(posedge CLK) disable iff (!NRST)
        (in_rec && thr_low && !thr_above) |=> !inrush_q_f)
        else $error("inrush not cleared at ninety percent");
    settle_rel_a: assert property (@(posedge CLK) disable iff (!NRST)
        (in_rec && st_done && !cold && !blocked) |=> !COLD_LOAD_ACTIVE)
        else $error("active not released after settle");
    maxblk_rel_a: assert property (@(posedge CLK) disable iff (!NRST)
        (in_rec && mb_done && !cold && !blocked) |=> !COLD_LOAD_ACTIVE)
        else $error("active not released after max-block");
    block_clear_a: assert property (@(posedge CLK) disable iff (!NRST)
        blocked |=> !COLD_LOAD_ACTIVE && state_q == cld_pkg::CLD_WARM ##1 !inrush_q_f)
        else $error("block did not clear the function");
    irq_level_a: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(COLD_LOAD_ACTIVE) && irq_mask_q[`CLD_IRQ_ON] |-> IRQ)
        else $error("masked-in activation gave no interrupt");
endmodule

/* File: testbench/cld_feeder.sv */
// far-side model: breaker auxiliary contact and current measurement
// assumes bench commands change right after a rising edge of clk
`timescale 1ns/1ns

module cld_feeder #(
    parameter logic [15:0] UC_LEVEL = 16'h0064
) (
    input  wire logic        clk,
    input  wire logic        open_cmd,  // breaker open request
    input  wire logic [15:0] amps,      // current to feed
    output logic             brk_open,  // breaker open level
    output logic             uc,        // undercurrent level
    output logic [15:0]      cur        // measured magnitude
);
    // one cycle of contact and measuring delay, as a real relay input has
    always_ff @(posedge clk) begin
        brk_open <= open_cmd;
        cur      <= amps;
        uc       <= (amps < UC_LEVEL);
    end
endmodule

/* File: testbench/tb.sv */
// bench for the cold load detector: bus tasks, read queue, pin checks
// assumes cld_top and the feeder model are compiled before it
`timescale 1ns/1ns

module tb;
    logic        CLK = 0, NRST = 0, brk = 0, eb = 0, ar = 0;
    logic [15:0] amps = 16'h01F4;
    logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [5:0]  aa = 0, ra = 0;
    logic [31:0] wd = 0, seed = 32'h23;
    logic [3:0]  ws = 4'hF;           // write byte lanes
    logic        bo, uc, act, irq, awr, wr_, bv, arr, rv;
    logic [15:0] cur;
    logic [1:0]  br, rr;
    logic [31:0] rd_;
    logic [65:0] q[$];                // expected {resp, mask, data}
    int          n_errors = 0, n_tests = 0;

    cld_feeder FEED (.clk(CLK), .open_cmd(brk), .amps(amps), .brk_open(bo), .uc(uc), .cur(cur));
    cld_top DUT (.CLK(CLK), .NRST(NRST), .BREAKER_POSITION_STATE(bo), .UNDERCURRENT(uc),
        .LOAD_CURRENT(cur), .EXT_BLOCK(eb), .AUTO_RECLOSE_RUNNING(ar), .COLD_LOAD_ACTIVE(act),
        .IRQ(irq), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aa), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ra), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd_), .S_AXI_RRESP(rr));

    initial forever #50 CLK = ~CLK;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask

    // write: address and data offered together, held until the response edge
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge CLK);
        awv <= 1; wv <= 1; aa <= a; wd <= d; bry <= 1;
        do @(posedge CLK); while (bv !== 1'b1);
        chk({30'h0, awr, wr_, br}, 34'h0000_000C);
        awv <= 0; wv <= 0; bry <= 0;
    endtask

    // read: the expectation is queued, the monitor below compares it
    task automatic rd(input logic [5:0] a, input logic [1:0] r, input logic [31:0] e, input logic [31:0] m);
        @(posedge CLK);
        q.push_back({r, m, e});
        arv <= 1; ra <= a; rry <= 1;
        do @(posedge CLK); while (rv !== 1'b1);
        arv <= 0; rry <= 0;
    endtask

    // monitor: each read answer is matched against the oldest note
    always @(posedge CLK) begin
        logic [65:0] e;
        if (rv === 1'b1 && rry === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            chk({rr, rd_ & e[63:32]}, {e[65:64], e[31:0]});
            chk({33'h0, arr}, 34'h1);
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog sized well above the few hundred cycles the tests need
    initial begin
        #3000000;
        n_errors++;
        conclude();
    end

    initial begin
        logic [31:0] ra_v[6] = '{32'h21, 32'h2710, 32'h3E8, 32'hC350, 32'h1000, 32'h0};
        logic [5:0]  ra_a[6] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h1C};
        cyc(6);
        NRST <= 1;
        for (int i = 0; i < 6; i++) rd(ra_a[i], 2'h0, ra_v[i], 32'hFFFFFFFF);
        rd(6'h20, 2'h2, 32'h0, 32'h0);        // unmapped place answers with an error
        $display("reset values done");
        wr(6'h04, 32'h5); wr(6'h08, 32'h5); wr(6'h0C, 32'h28); wr(6'h10, 32'h3E8); wr(6'h1C, 32'hF);
        // breaker open while current flows: only breaker and or modes see cold
        for (int m = 0; m < 4; m++) begin
            wr(6'h00, 32'h1 | (m << 1));
            brk <= 1; cyc(20);
            chk({33'h0, act}, {33'h0, m == 0 || m == 3});
            rd(6'h14, 2'h0, (m == 0 || m == 3) ? 32'h5 : 32'h0, 32'h7);
            brk <= 0; cyc(20);
        end
        // no current as well: undercurrent and and modes now see cold
        for (int m = 1; m < 3; m++) begin
            wr(6'h00, 32'h1 | (m << 1));
            brk <= 1; amps <= 16'h0000; cyc(20);
            chk({33'h0, act}, 34'h1);
            brk <= 0; amps <= 16'h01F4; cyc(20);
            chk({33'h0, act}, 34'h0);
        end
        chk({33'h0, irq}, 34'h1);
        rd(6'h18, 2'h0, 32'h3, 32'h3);
        rd(6'h18, 2'h0, 32'h0, 32'h3);        // read has cleared the sticky bits
        chk({33'h0, irq}, 34'h0);
        $display("modes done");
        // long inrush above threshold: only the max-block time ends the output
        wr(6'h00, 32'h1); brk <= 1; cyc(20); brk <= 0;
        repeat (30) begin @(posedge CLK); amps <= 16'(32'h07D0 + rnd() % 1000); end
        chk({33'h0, act}, 34'h1);
        cyc(20);
        chk({33'h0, act}, 34'h0);
        rd(6'h18, 2'h0, 32'hE, 32'hE);
        $display("max block done");
        // inrush then current at exactly ninety percent: settle time releases early
        brk <= 1; cyc(20); brk <= 0; amps <= 16'h07D0; cyc(10);
        amps <= 16'h0384; cyc(12);
        chk({33'h0, act}, 34'h0);
        $display("settle done");
        // a single byte lane changes only its own byte
        ws <= 4'h1; wr(6'h04, 32'hFFFF_FF07); ws <= 4'hF;
        rd(6'h04, 2'h0, 32'h7, 32'hFFFFFFFF);
        // each selectable block keeps the output low and flags the state
        for (int b = 3; b < 6; b++) begin
            wr(6'h00, 32'h1 | (32'h1 << b));
            eb <= 1; ar <= 1; brk <= 1; cyc(20);
            chk({33'h0, act}, 34'h0);
            rd(6'h14, 2'h0, 32'h10, 32'h11);
            brk <= 0; eb <= 0; ar <= 0; cyc(5);
        end
        $display("blocking done");
        cyc(3);
        conclude();
    end
endmodule
